// ==== design/top_ctrl_regs.sv ====
// Top-level control and status register group with APB slave.
//
// Added by the designer: the APB slave port.
`default_nettype none
module top_ctrl_regs #(
    parameter int N_CNT = 8,
    parameter int BUS_W = 8
) (
    // Clock, reset and freeze
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               clk_en,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Monitored pins and map pulses, asynchronous
    input  wire logic               in_frame_pulse,
    input  wire logic               rx_frame_pulse,
    input  wire logic               sys_clock_in,
    input  wire logic               serial_ref_clock,
    input  wire logic               in_map_pulse,
    input  wire logic               out_map_pulse,
    // Sub-block pending levels, bit 0 is the incoming status block
    input  wire logic [13:0]        sub_pending,
    // Performance counter snapshot
    output logic                    counter_snapshot,
    input  wire logic [N_CNT-1:0]   counter_copied,
    // Receive frame start after the programmed delay
    output logic                    rx_frame_start,
    // Signaling header user bits
    output logic      [1:0]         working_link_user_bits,
    output logic      [1:0]         protect_link_user_bits,
    // Encoded line loopback
    input  wire tlcs_pkg::line_pair_t line_encoder_out,
    input  wire tlcs_pkg::line_pair_t line_rx_in,
    output tlcs_pkg::line_pair_t    line_decoder_in,
    // Transmit to receive bus loopback
    input  wire logic [BUS_W-1:0]   in_signaling_merge,
    input  wire logic [BUS_W-1:0]   rx_bus_in,
    output logic      [BUS_W-1:0]   out_signaling_extract,
    // Interrupt
    output logic                    irq_n
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] idx);
        hit = (addr == {idx[5:0], 2'b00});
    endfunction : hit

    logic setup;
    logic done;
    logic wr_done;
    logic rd_done;
    logic pready_r;
    logic h_dly;
    logic h_user;
    logic h_src;
    logic h_stat;
    logic h_en;
    logic h_lb;
    logic h_act;
    logic mapped;
    logic [15:0] rd_bits;

    assign setup   = psel & ~penable;
    assign done    = psel & penable & pready_r;
    assign wr_done = done & pwrite;
    assign rd_done = done & ~pwrite;
    assign h_dly   = hit(paddr, tlcs_pkg::IDX_RX_DELAY);
    assign h_user  = hit(paddr, tlcs_pkg::IDX_USER_BITS);
    assign h_src   = hit(paddr, tlcs_pkg::IDX_MSTR_SRC);
    assign h_stat  = hit(paddr, tlcs_pkg::IDX_TOP_STAT);
    assign h_en    = hit(paddr, tlcs_pkg::IDX_TOP_EN);
    assign h_lb    = hit(paddr, tlcs_pkg::IDX_LOOPBACK);
    assign h_act   = hit(paddr, tlcs_pkg::IDX_ACTIVITY);
    assign mapped  = h_dly | h_user | h_src | h_stat | h_en | h_lb | h_act;
    assign rd_bits = rd_done ? prdata[15:0] : 16'h0000;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [tlcs_pkg::NSYNC-1:0] async_in;
    logic [tlcs_pkg::NSYNC-1:0] meta_r;
    logic [tlcs_pkg::NSYNC-1:0] sync_r;
    logic [tlcs_pkg::NSYNC-1:0] prev_r;
    logic [tlcs_pkg::NSYNC-1:0] rise;

    assign async_in = {out_map_pulse, in_map_pulse, serial_ref_clock,
                       sys_clock_in, rx_frame_pulse, in_frame_pulse};
    assign rise     = sync_r & ~prev_r;

    // Edge detection looks only at the second stage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else if (clk_en) begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // ****************************************************************
    // Writable registers
    // ****************************************************************
    logic [15:0] dly_r;
    logic [15:0] user_r;
    logic [15:0] en_r;
    logic [15:0] lb_r;

    // Bits outside each write mask are dropped on write, so they read as zero, apart from TIP_BIT in the delay register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_r  <= tlcs_pkg::RESET_VAL;
            user_r <= tlcs_pkg::RESET_VAL;
            en_r   <= tlcs_pkg::RESET_VAL;
            lb_r   <= tlcs_pkg::RESET_VAL;
        end else if (clk_en && wr_done) begin
            if (h_dly) begin
                dly_r <= pwdata[15:0] & tlcs_pkg::DLY_WMASK;
            end
            if (h_user) begin
                user_r <= pwdata[15:0] & tlcs_pkg::USER_WMASK;
            end
            if (h_en) begin
                en_r <= pwdata[15:0] & tlcs_pkg::EN_WMASK;
            end
            if (h_lb) begin
                lb_r <= pwdata[15:0] & tlcs_pkg::LB_WMASK;
            end
        end
    end

    assign working_link_user_bits =
        user_r[tlcs_pkg::WUSER_LSB +: 2];
    assign protect_link_user_bits =
        user_r[tlcs_pkg::PUSER_LSB +: 2];

    // ****************************************************************
    // Connection-map pulse status and interrupt
    // ****************************************************************
    logic in_map_st_r;
    logic out_map_st_r;
    logic in_samp;
    logic out_samp;
    logic top_pending;

    // The frame pulse itself marks the frame in telecom mode and the
    // multiframe in switched mode, so one sampling point serves both.
    assign in_samp  = rise[tlcs_pkg::S_IN_FP]
                    & sync_r[tlcs_pkg::S_INMAP];
    assign out_samp = rise[tlcs_pkg::S_RX_FP]
                    & sync_r[tlcs_pkg::S_OUMAP];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_map_st_r  <= 1'b0;
            out_map_st_r <= 1'b0;
        end else if (clk_en) begin
            if (in_samp) begin
                in_map_st_r <= 1'b1;
            end else if (h_stat && rd_bits[tlcs_pkg::IN_MAP_BIT]) begin
                in_map_st_r <= 1'b0;
            end
            if (out_samp) begin
                out_map_st_r <= 1'b1;
            end else if (h_stat && rd_bits[tlcs_pkg::OUT_MAP_BIT]) begin
                out_map_st_r <= 1'b0;
            end
        end
    end

    assign top_pending =
        (in_map_st_r & en_r[tlcs_pkg::IN_MAP_BIT])
      | (out_map_st_r & en_r[tlcs_pkg::OUT_MAP_BIT]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_n <= 1'b1;
        end else if (clk_en) begin
            irq_n <= ~top_pending;
        end
    end

    // ****************************************************************
    // Activity monitor
    // ****************************************************************
    logic act_rx_r;
    logic act_sys_r;
    logic act_ref_r;
    logic act_in_r;
    logic [15:0] act_clr;

    // Only reads clear; a write to this address never touches the bits.
    assign act_clr = h_act ? rd_bits : 16'h0000;

    // Each bit watches a single input, so one rising edge suffices.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_rx_r  <= 1'b0;
            act_sys_r <= 1'b0;
            act_ref_r <= 1'b0;
            act_in_r  <= 1'b0;
        end else if (clk_en) begin
            act_rx_r  <= rise[tlcs_pkg::S_RX_FP]
                       | (act_rx_r & ~act_clr[tlcs_pkg::ACT_RX_BIT]);
            act_sys_r <= rise[tlcs_pkg::S_SYS]
                       | (act_sys_r & ~act_clr[tlcs_pkg::ACT_SYS_BIT]);
            act_ref_r <= rise[tlcs_pkg::S_REF]
                       | (act_ref_r & ~act_clr[tlcs_pkg::ACT_REF_BIT]);
            act_in_r  <= rise[tlcs_pkg::S_IN_FP]
                       | (act_in_r & ~act_clr[tlcs_pkg::ACT_IN_BIT]);
        end
    end

    // ****************************************************************
    // Counter snapshot and transfer-in-progress
    // ****************************************************************
    logic             tip_r;
    logic [N_CNT-1:0] seen_r;
    logic [N_CNT-1:0] seen_nxt;
    logic             trig;

    assign trig     = wr_done & h_act;
    assign seen_nxt = seen_r | counter_copied;

    // Counters copy to holding and then clear on the snapshot pulse.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_snapshot <= 1'b0;
        end else if (clk_en) begin
            counter_snapshot <= trig;
        end
    end

    // A retrigger restarts the wait so old acknowledges do not count.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tip_r  <= 1'b0;
            seen_r <= '0;
        end else if (clk_en) begin
            if (trig) begin
                tip_r  <= 1'b1;
                seen_r <= '0;
            end else if (tip_r) begin
                seen_r <= seen_nxt;
                if (&seen_nxt) begin
                    tip_r <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Receive frame delay
    // ****************************************************************
    tlcs_pkg::dly_state_t     dly_st_r;
    logic [tlcs_pkg::DLY_W-1:0] dly_cnt_r;

    // A pulse arriving mid-count restarts it from the new frame.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_st_r       <= tlcs_pkg::DLY_IDLE;
            dly_cnt_r      <= '0;
            rx_frame_start <= 1'b0;
        end else if (clk_en) begin
            rx_frame_start <= 1'b0;
            if (rise[tlcs_pkg::S_RX_FP]) begin
                dly_st_r  <= tlcs_pkg::DLY_RUN;
                dly_cnt_r <= dly_r[tlcs_pkg::DLY_W-1:0];
            end else begin
                case (dly_st_r)
                    tlcs_pkg::DLY_RUN: begin
                        if (dly_cnt_r == '0) begin
                            rx_frame_start <= 1'b1;
                            dly_st_r       <= tlcs_pkg::DLY_IDLE;
                        end else begin
                            dly_cnt_r <= dly_cnt_r - 1'b1;
                        end
                    end
                    default: begin
                        dly_st_r <= tlcs_pkg::DLY_IDLE;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Diagnostic loopbacks
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_decoder_in       <= '0;
            out_signaling_extract <= '0;
        end else if (clk_en) begin
            if (lb_r[tlcs_pkg::ENC_LB_BIT]) begin
                line_decoder_in <= line_encoder_out;
            end else begin
                line_decoder_in <= line_rx_in;
            end
            if (lb_r[tlcs_pkg::TXRX_LB_BIT]) begin
                out_signaling_extract <= in_signaling_merge;
            end else begin
                out_signaling_extract <= rx_bus_in;
            end
        end
    end

    // ****************************************************************
    // Read data and bus answer
    // ****************************************************************
    logic [15:0] rd_val;
    // Sub-block bits are live levels; they clear in their own block.
    always_comb begin
        rd_val = 16'h0000;
        if (h_dly) begin
            rd_val = dly_r;
            rd_val[tlcs_pkg::TIP_BIT] = tip_r;
        end else if (h_user) begin
            rd_val = user_r;
        end else if (h_src) begin
            rd_val[13:0] = sub_pending;
            rd_val[tlcs_pkg::TOP_SRC_BIT] = top_pending;
        end else if (h_stat) begin
            rd_val[tlcs_pkg::IN_MAP_BIT]  = in_map_st_r;
            rd_val[tlcs_pkg::OUT_MAP_BIT] = out_map_st_r;
        end else if (h_en) begin
            rd_val = en_r;
        end else if (h_lb) begin
            rd_val = lb_r;
        end else if (h_act) begin
            rd_val[tlcs_pkg::ACT_RX_BIT]  = act_rx_r;
            rd_val[tlcs_pkg::ACT_SYS_BIT] = act_sys_r;
            rd_val[tlcs_pkg::ACT_REF_BIT] = act_ref_r;
            rd_val[tlcs_pkg::ACT_IN_BIT]  = act_in_r;
        end
    end

    // Data is captured in setup, so there is no wait state. A read then
    // clears only the bits it returned, so a later event is never lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            prdata   <= 32'h0000_0000;
            pslverr  <= 1'b0;
        end else if (clk_en) begin
            if (setup) begin
                pready_r <= 1'b1;
                pslverr  <= ~mapped;
                if (pwrite) begin
                    prdata <= 32'h0000_0000;
                end else begin
                    prdata <= {16'h0000, rd_val};
                end
            end else if (done) begin
                pready_r <= 1'b0;
                pslverr  <= 1'b0;
            end
        end
    end
    assign pready = pready_r;

endmodule : top_ctrl_regs
`default_nettype wire

// ==== design/tlcs_pkg.sv ====
// Constants and types shared by the top-level control and status registers.
`default_nettype none
package tlcs_pkg;

    // ****************************************************************
    // Register indices; byte address is four times the index.
    // ****************************************************************
    localparam logic [7:0] IDX_RX_DELAY  = 8'h07;
    localparam logic [7:0] IDX_USER_BITS = 8'h08;
    localparam logic [7:0] IDX_MSTR_SRC  = 8'h10;
    localparam logic [7:0] IDX_TOP_STAT  = 8'h11;
    localparam logic [7:0] IDX_TOP_EN    = 8'h12;
    localparam logic [7:0] IDX_LOOPBACK  = 8'h13;
    localparam logic [7:0] IDX_ACTIVITY  = 8'h14;

    // ****************************************************************
    // Field positions, widths, write masks and reset values.
    // ****************************************************************
    localparam int          TIP_BIT     = 15;
    localparam int          DLY_W       = 14;
    localparam int          WUSER_LSB   = 2;
    localparam int          PUSER_LSB   = 0;
    localparam int          TOP_SRC_BIT = 14;
    localparam int          IN_MAP_BIT  = 6;
    localparam int          OUT_MAP_BIT = 5;
    localparam int          ENC_LB_BIT  = 1;
    localparam int          TXRX_LB_BIT = 0;
    localparam int          ACT_RX_BIT  = 6;
    localparam int          ACT_SYS_BIT = 5;
    localparam int          ACT_REF_BIT = 4;
    localparam int          ACT_IN_BIT  = 0;
    localparam logic [15:0] DLY_WMASK   = 16'h3FFF;
    localparam logic [15:0] USER_WMASK  = 16'h000F;
    localparam logic [15:0] EN_WMASK    = 16'h007F;
    localparam logic [15:0] LB_WMASK    = 16'h0007;
    localparam logic [15:0] RESET_VAL   = 16'h0000;

    // ****************************************************************
    // Synchroniser lanes for pins from outside the clock domain.
    // ****************************************************************
    localparam int NSYNC   = 6;
    localparam int S_IN_FP = 0;
    localparam int S_RX_FP = 1;
    localparam int S_SYS   = 2;
    localparam int S_REF   = 3;
    localparam int S_INMAP = 4;
    localparam int S_OUMAP = 5;

    localparam int LINE_W = 10;

    typedef struct packed {
        logic [LINE_W-1:0] working;
        logic [LINE_W-1:0] protect;
    } line_pair_t;

    typedef enum logic {DLY_IDLE, DLY_RUN} dly_state_t;

endpackage : tlcs_pkg
`default_nettype wire

// ==== tb/top_ctrl_regs_properties.sv ====
// Concurrent checks on the ports of the top-level control register group.
`default_nettype none
module top_ctrl_regs_properties #(
    parameter int N_CNT = 8,
    parameter int BUS_W = 8
) (
    // Clock, reset and register bus
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 clk_en,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // Status and control pins
    input wire logic [13:0]          sub_pending,
    input wire logic                 counter_snapshot,
    input wire logic                 rx_frame_start,
    input wire logic [1:0]           working_link_user_bits,
    input wire logic [1:0]           protect_link_user_bits,
    input wire logic                 irq_n,
    // Loopback paths
    input wire tlcs_pkg::line_pair_t line_encoder_out,
    input wire tlcs_pkg::line_pair_t line_rx_in,
    input wire tlcs_pkg::line_pair_t line_decoder_in,
    input wire logic [BUS_W-1:0]     in_signaling_merge,
    input wire logic [BUS_W-1:0]     rx_bus_in,
    input wire logic [BUS_W-1:0]     out_signaling_extract
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Shadow copies of the loopback and enable fields.
    // ****************************************************************
    logic       done;
    logic [2:0] lb_r;
    logic [1:0] en_r;

    // The shadows let the mux and mask checks run without peeking inside.
    assign done = psel && penable && pready && clk_en;

    function automatic logic mapped(input logic [7:0] a);
        return a inside {8'h1C, 8'h20, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h50};
    endfunction : mapped

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lb_r <= 3'h0;
        end else if (done && pwrite && paddr == 8'h4C) begin
            lb_r <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= 2'h0;
        end else if (done && pwrite && paddr == 8'h48) begin
            en_r <= pwdata[6:5];
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    snap_pulse_a: assert property (
        done && pwrite && paddr == 8'h50 |=> counter_snapshot)
        else $error("snapshot pulse missing after trigger write");
    snap_cause_a: assert property (
        counter_snapshot && $past(clk_en)
        |-> $past(done && pwrite && paddr == 8'h50))
        else $error("snapshot pulse without trigger write");
    user_bits_a: assert property (
        done && pwrite && paddr == 8'h20 |=>
        {working_link_user_bits, protect_link_user_bits} == $past(pwdata[3:0]))
        else $error("header user bits differ from written value");
    enc_loop_a: assert property (
        $past(presetn) && $past(clk_en) |-> line_decoder_in ==
        $past(lb_r[1] ? line_encoder_out : line_rx_in))
        else $error("decoder input takes the wrong source");
    txrx_loop_a: assert property (
        $past(presetn) && $past(clk_en) |-> out_signaling_extract ==
        $past(lb_r[0] ? in_signaling_merge : rx_bus_in))
        else $error("extractor input takes the wrong source");
    irq_mask_a: assert property (
        $past(presetn) && $past(en_r) == 2'b00 |-> irq_n)
        else $error("interrupt asserted with both enables off");
    src_read_a: assert property (
        done && !pwrite && paddr == 8'h40 && $past(clk_en) |->
        prdata[13:0] == $past(sub_pending) && prdata[31:16] == 16'h0000)
        else $error("source register differs from pending inputs");
    unmapped_a: assert property (
        done |-> pslverr == !mapped(paddr) && (pwrite || mapped(paddr)
        || prdata == 32'h0000_0000))
        else $error("unmapped access answered wrongly");
    ready_pulse_a: assert property (
        pready && clk_en |=> !pready)
        else $error("ready held for more than one cycle");
    start_pulse_a: assert property (
        rx_frame_start && clk_en |=> !rx_frame_start)
        else $error("frame start longer than one cycle");
endmodule : top_ctrl_regs_properties

bind top_ctrl_regs top_ctrl_regs_properties #(
    .N_CNT(N_CNT),
    .BUS_W(BUS_W)
) top_ctrl_regs_properties_i (.*);
`default_nettype wire

// ==== tb/top_ctrl_regs_test.sv ====
// Self-checking register-level testbench of the control register group.
`default_nettype none
module top_ctrl_regs_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Stimulus signals, bus and compare tasks.
    // ****************************************************************
    localparam logic [19:0] ENC = 20'h2AB55;
    localparam logic [19:0] RXL = 20'h12345;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, in_signaling_merge = 8'hA5, rx_bus_in = 8'h3C;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr, counter_snapshot, rx_frame_start, irq_n;
    logic [5:0] pin_v = 6'h00;
    logic [1:0] cc = 2'b00, working_link_user_bits, protect_link_user_bits;
    logic [13:0] sub_pending = 14'h0000;
    logic [7:0] out_signaling_extract;
    tlcs_pkg::line_pair_t line_encoder_out = ENC, line_rx_in = RXL;
    tlcs_pkg::line_pair_t line_decoder_in;
    logic [7:0] rw_a [4] = '{8'h1C, 8'h20, 8'h48, 8'h4C};
    logic [31:0] rw_m [4] = '{32'h3FFF, 32'hF, 32'h60, 32'h3};
    int num_errors = 0, cmp_count = 0, cyc = 0;

    top_ctrl_regs #(.N_CNT(2)) top_ctrl_regs_i (.*,
        .in_frame_pulse(pin_v[0]), .rx_frame_pulse(pin_v[1]),
        .sys_clock_in(pin_v[2]), .serial_ref_clock(pin_v[3]),
        .in_map_pulse(pin_v[4]), .out_map_pulse(pin_v[5]),
        .counter_copied(cc));

    always #10 pclk = ~pclk;

    task automatic end_of_test;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    // A hung handshake ends here rather than spinning forever.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Answers are read settled mid-cycle and stand at the next edge.
        @(negedge pclk);
        while (pready !== 1'b1) @(negedge pclk);
        rdat = prdata;
        rerr = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 16'h0000);
        chk($sformatf("register %h", a), rdat, e);
    endtask : rd

    task automatic pulse(input int b);
        @(posedge pclk);
        pin_v[b] <= 1'b1;
        repeat (3) @(posedge pclk);
        pin_v[b] <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask : pulse

    // Counts from the pin rising: two sync stages and an edge detect first.
    task automatic frame_delay(input logic [13:0] d);
        int n;
        apb(1'b1, 8'h1C, {2'b00, d});
        @(posedge pclk);
        pin_v[1] <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (rx_frame_start !== 1'b1 && n < 100);
        chk("frame start delay", 32'(n), 32'(d) + 32'd4);
        @(posedge pclk);
        pin_v[1] <= 1'b0;
    endtask : frame_delay

    // ****************************************************************
    // Test sequence.
    // ****************************************************************
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) rd(rw_a[i], 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, rw_a[i], 16'hFF80 | rw_m[i][15:0]);
            rd(rw_a[i], rw_m[i]);
        end
        apb(1'b1, 8'h20, 16'h0009);
        @(negedge pclk);
        chk("working user", 32'(working_link_user_bits), 32'h2);
        chk("protect user", 32'(protect_link_user_bits), 32'h1);
        apb(1'b0, 8'h24, 16'h0000);
        chk("unmapped error", 32'(rerr), 32'h1);
        chk("unmapped data", rdat, 32'h0);
        apb(1'b1, 8'h50, 16'h0000);
        rd(8'h1C, 32'hBFFF);
        cc <= 2'b01;
        @(posedge pclk);
        cc <= 2'b00;
        rd(8'h1C, 32'hBFFF);
        cc <= 2'b10;
        @(posedge pclk);
        cc <= 2'b00;
        rd(8'h1C, 32'h3FFF);
        sub_pending <= 14'h2A5A;
        apb(1'b1, 8'h48, 16'h0060);
        rd(8'h40, 32'h2A5A);
        rd(8'h40, 32'h2A5A);
        frame_delay(14'd1);
        frame_delay(14'd5);
        frame_delay(14'd0);
        pin_v[4] <= 1'b1;
        pulse(0);
        chk("irq in map", 32'(irq_n), 32'h0);
        rd(8'h40, 32'h6A5A);
        rd(8'h44, 32'h40);
        rd(8'h44, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq cleared", 32'(irq_n), 32'h1);
        pin_v[4] <= 1'b0;
        pin_v[5] <= 1'b1;
        pulse(1);
        chk("irq out map", 32'(irq_n), 32'h0);
        rd(8'h44, 32'h20);
        pin_v[5] <= 1'b0;
        apb(1'b1, 8'h48, 16'h0000);
        pin_v[4] <= 1'b1;
        pulse(0);
        chk("irq masked", 32'(irq_n), 32'h1);
        rd(8'h44, 32'h40);
        pin_v[4] <= 1'b0;
        rd(8'h50, 32'h41);
        rd(8'h50, 32'h0);
        for (int b = 0; b < 4; b++) pulse(b);
        apb(1'b1, 8'h50, 16'h0000);
        rd(8'h50, 32'h71);
        rd(8'h50, 32'h0);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 8'h4C, 16'(m));
            repeat (2) @(posedge pclk);
            #1;
            chk("decoder in", 32'(line_decoder_in),
                m[1] ? ENC : RXL);
            chk("extract in", 32'(out_signaling_extract),
                m[0] ? 32'hA5 : 32'h3C);
        end
        end_of_test();
    end
endmodule : top_ctrl_regs_test
`default_nettype wire
